//--- design/dskip_decoder.sv
// Decoder and executor for decrement-and-skip-on-zero and -on-nonzero.
`timescale 1ns/1ps
`include "dskip_defs.svh"
module dskip_decoder
    import dskip_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Instruction stream
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic next_two_word_i,
    input wire logic extended_set_i,
    // Operand and bank
    input wire logic [7:0] file_data_i,
    input wire logic [3:0] bank_select_register_i,
    // Memory and working register writes
    output logic [11:0] file_addr_o,
    output logic indexed_mode_o,
    output logic [7:0] result_o,
    output logic wreg_we_o,
    output logic file_we_o,
    // Control
    output logic skip_o,
    output logic busy_o,
    output logic [1:0] phase_o,
    output logic cycle_end_o
);
    exec_state_type state;
    logic [15:0] instr;
    logic [1:0] flush_left;
    logic is_zero_op;
    logic is_nonzero_op;
    logic [7:0] dec_value;
    logic take_skip;

    function automatic logic match_opc(input logic [15:0] w, input logic [5:0] opc);
        match_opc = (w[`OPC_MSB:`OPC_LSB] == opc);
    endfunction : match_opc

    dskip_qphase dskip_qphase_i (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .phase_o(phase_o),
        .cycle_end_o(cycle_end_o)
    );

    assign is_zero_op = match_opc(instr, `OPC_SKIP_ZERO);
    assign is_nonzero_op = match_opc(instr, `OPC_SKIP_NONZERO);
    assign dec_value = file_data_i - 8'h01;
    // Only the result drives the skip; no status flag is touched here.
    assign take_skip = (is_zero_op && dec_value == 8'h00)
        || (is_nonzero_op && dec_value != 8'h00);
    assign busy_o = (state != EXEC_IDLE);

    // Instruction latch and sequence.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state <= EXEC_IDLE;
            instr <= 16'h0000;
            flush_left <= 2'h0;
        end else if (cycle_end_o) begin
            case (state)
                EXEC_IDLE: begin
                    if (instr_valid_i && (match_opc(instr_i, `OPC_SKIP_ZERO)
                        || match_opc(instr_i, `OPC_SKIP_NONZERO))) begin
                        instr <= instr_i;
                        state <= EXEC_RUN;
                    end
                end
                EXEC_RUN: begin
                    if (take_skip) begin
                        // Prefetched word(s) become no-operations.
                        flush_left <= next_two_word_i ? 2'h2 : 2'h1;
                        state <= EXEC_FLUSH;
                    end else begin
                        state <= EXEC_IDLE;
                    end
                end
                EXEC_FLUSH: begin
                    flush_left <= flush_left - 2'h1;
                    if (flush_left == 2'h1) begin
                        state <= EXEC_IDLE;
                    end
                end
                default: state <= EXEC_IDLE;
            endcase
        end
    end

    // Address formation, latched in the first phase of the executing cycle.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            file_addr_o <= 12'h000;
            indexed_mode_o <= 1'b0;
        end else if (state == EXEC_RUN && phase_o == 2'h0) begin
            if (instr[`BANK_BIT]) begin
                file_addr_o <= {bank_select_register_i, instr[7:0]};
                indexed_mode_o <= 1'b0;
            end else begin
                // Low half of the access bank maps to bank 0, high half to bank 15.
                file_addr_o <= {{4{instr[7]}}, instr[7:0]};
                indexed_mode_o <= extended_set_i && (instr[7:0] <= `INDEXED_LIMIT);
            end
        end
    end

    // Result write in the last phase of the executing cycle.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            result_o <= 8'h00;
            wreg_we_o <= 1'b0;
            file_we_o <= 1'b0;
            skip_o <= 1'b0;
        end else begin
            wreg_we_o <= 1'b0;
            file_we_o <= 1'b0;
            if (state == EXEC_RUN && cycle_end_o) begin
                result_o <= dec_value;
                wreg_we_o <= !instr[`DEST_BIT];
                file_we_o <= instr[`DEST_BIT];
                skip_o <= take_skip;
            end else if (state == EXEC_IDLE) begin
                skip_o <= 1'b0;
            end
        end
    end

    property p_dest_route;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && cycle_end_o) |=> (wreg_we_o != file_we_o);
    endproperty
    a_dest_route: assert property (p_dest_route) else $error("dest write not exclusive");

    property p_result_dec;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && cycle_end_o) |=> (result_o == $past(file_data_i) - 8'h01);
    endproperty
    a_result_dec: assert property (p_result_dec) else $error("result not decremented");

    property p_zero_skip;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && cycle_end_o && is_zero_op && file_data_i == 8'h01)
            |=> (state == EXEC_FLUSH);
    endproperty
    a_zero_skip: assert property (p_zero_skip) else $error("zero skip not taken");

    property p_nonzero_skip;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && cycle_end_o && is_nonzero_op && file_data_i != 8'h01)
            |=> (state == EXEC_FLUSH);
    endproperty
    a_nonzero_skip: assert property (p_nonzero_skip) else $error("nonzero skip missed");

    property p_no_skip_one_cycle;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && cycle_end_o && !take_skip) |=> (state == EXEC_IDLE);
    endproperty
    a_no_skip_one_cycle: assert property (p_no_skip_one_cycle) else $error("extra cycle");

    property p_flush_two;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && cycle_end_o && take_skip && next_two_word_i)
            |=> (state == EXEC_FLUSH) [*8];
    endproperty
    a_flush_two: assert property (p_flush_two) else $error("two-word flush short");

    // The executing cycle's own write pulse lands on the first flush clock.
    property p_flush_no_write;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_FLUSH)
            |-> (skip_o && ((!wreg_we_o && !file_we_o) || $past(state) == EXEC_RUN));
    endproperty
    a_flush_no_write: assert property (p_flush_no_write) else $error("write during flush");

    property p_bank_select;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && phase_o == 2'h0 && instr[`BANK_BIT])
            |=> (file_addr_o[11:8] == $past(bank_select_register_i) && !indexed_mode_o);
    endproperty
    a_bank_select: assert property (p_bank_select) else $error("bank select wrong");

    property p_indexed;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && phase_o == 2'h0 && !instr[`BANK_BIT] && extended_set_i
            && instr[7:0] <= 8'h5F) |=> indexed_mode_o;
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed mode missed");

    property p_opcode_refused;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_IDLE && cycle_end_o && !(match_opc(instr_i, `OPC_SKIP_ZERO)
            || match_opc(instr_i, `OPC_SKIP_NONZERO))) |=> (state == EXEC_IDLE);
    endproperty
    a_opcode_refused: assert property (p_opcode_refused) else $error("foreign opcode ran");

    property p_we_pulse;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (wreg_we_o || file_we_o) |=> (!wreg_we_o && !file_we_o);
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write enable longer than a clock");

    property p_flush_one;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && cycle_end_o && take_skip && !next_two_word_i)
            |=> (state == EXEC_FLUSH) [*4] ##1 (state == EXEC_IDLE);
    endproperty
    a_flush_one: assert property (p_flush_one) else $error("one-word flush wrong length");

    property p_access_bank;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == EXEC_RUN && phase_o == 2'h0 && !instr[`BANK_BIT])
            |=> (file_addr_o[11:8] == {4{$past(instr[7])}});
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank wrong");
endmodule : dskip_decoder

//--- design/dskip_defs.svh
// Constants for the decrement-and-skip instruction decoder.
`ifndef DSKIP_DEFS_SVH
`define DSKIP_DEFS_SVH
`define OPC_SKIP_ZERO 6'h0B
`define OPC_SKIP_NONZERO 6'h13
`define OPC_MSB 15
`define OPC_LSB 10
`define DEST_BIT 9
`define BANK_BIT 8
`define INDEXED_LIMIT 8'h5F
`define QPHASES 2'h3
`endif

//--- design/dskip_pkg.sv
// Types for the decrement-and-skip instruction decoder.
package dskip_pkg;
    typedef enum logic [1:0] {
        EXEC_IDLE,
        EXEC_RUN,
        EXEC_FLUSH
    } exec_state_type;
endpackage : dskip_pkg

//--- design/dskip_qphase.sv
// Four-phase divider that paces one instruction cycle.
`timescale 1ns/1ps
`include "dskip_defs.svh"
module dskip_qphase (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Phase outputs
    output logic [1:0] phase_o,
    output logic cycle_end_o
);
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            phase_o <= 2'h0;
        end else begin
            phase_o <= phase_o + 2'h1;
        end
    end
    assign cycle_end_o = (phase_o == 2'(`QPHASES));
endmodule : dskip_qphase

//--- verif/tb_decrement_skip_instructions.sv
// Self-checking bench for the decrement-and-skip instruction decoder.
`timescale 1ns/1ps
`include "dskip_defs.svh"
module tb_decrement_skip_instructions;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic instr_valid_i = 1'b0;
    logic next_two_word_i = 1'b0;
    logic extended_set_i = 1'b0;
    logic [7:0] file_data_i = 8'h00;
    logic [3:0] bank_select_register_i = 4'h0;
    logic [11:0] file_addr_o;
    logic [7:0] result_o;
    logic [1:0] phase_o;
    logic indexed_mode_o, wreg_we_o, file_we_o, skip_o, busy_o, cycle_end_o;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    dskip_decoder dskip_decoder_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .instr_i(instr_i), .instr_valid_i(instr_valid_i), .next_two_word_i(next_two_word_i),
        .extended_set_i(extended_set_i), .file_data_i(file_data_i),
        .bank_select_register_i(bank_select_register_i), .file_addr_o(file_addr_o),
        .indexed_mode_o(indexed_mode_o), .result_o(result_o), .wreg_we_o(wreg_we_o),
        .file_we_o(file_we_o), .skip_o(skip_o), .busy_o(busy_o), .phase_o(phase_o),
        .cycle_end_o(cycle_end_o));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic tally_and_finish;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // A hang past a thousand instruction cycles (4000 clocks) means a lost handshake.
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic cmp_v(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_v
    task automatic cmp_n(input int got, input int exp);
        checks++;
        if (got != exp) begin
            error_cnt++;
            $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : cmp_n
    // Issues one instruction at an idle cycle end and judges the write-back pulse.
    task automatic run(input logic [5:0] opc, input logic d, input logic a,
        input logic [7:0] f, input logic [7:0] dat, input logic ext, input logic tw,
        input logic sk);
        int n;
        int pulses;
        n = 0;
        pulses = 0;
        while (!(cycle_end_o === 1'b1 && busy_o === 1'b0)) begin
            @(posedge clk_sys_i);
            #1;
        end
        instr_i = {opc, d, a, f};
        instr_valid_i = 1'b1;
        next_two_word_i = tw;
        extended_set_i = ext;
        file_data_i = dat;
        @(posedge clk_sys_i);
        #1;
        instr_valid_i = 1'b0;
        while ((busy_o === 1'b1 || wreg_we_o === 1'b1 || file_we_o === 1'b1) && n < 40) begin
            if (wreg_we_o === 1'b1 || file_we_o === 1'b1) begin
                pulses++;
                cmp_v(result_o, {4'h0, dat - 8'h01});
                cmp_v(file_we_o, d);
                cmp_v(wreg_we_o, !d);
                cmp_v(file_addr_o, a ? {bank_select_register_i, f} : {{4{f[7]}}, f});
                cmp_v(indexed_mode_o, ext && !a && f <= `INDEXED_LIMIT);
                cmp_v(skip_o, sk);
                cmp_v(phase_o, 12'h000);
            end
            if (busy_o === 1'b1) begin
                n++;
            end
            @(posedge clk_sys_i);
            #1;
        end
        cmp_n(pulses, 1);
        cmp_n(n, (`QPHASES + 1) * (sk ? (tw ? 3 : 2) : 1));
    endtask : run
    task automatic t_zero;
        bank_select_register_i = 4'h5;
        run(`OPC_SKIP_ZERO, 1'b0, 1'b0, 8'h80, 8'h00, 1'b1, 1'b0, 1'b0);
        run(`OPC_SKIP_ZERO, 1'b1, 1'b1, 8'hA3, 8'h01, 1'b0, 1'b0, 1'b1);
        run(`OPC_SKIP_ZERO, 1'b1, 1'b1, 8'hA3, 8'h01, 1'b0, 1'b1, 1'b1);
    endtask : t_zero
    task automatic t_nonzero;
        bank_select_register_i = 4'hC;
        run(`OPC_SKIP_NONZERO, 1'b0, 1'b1, 8'h10, 8'h01, 1'b0, 1'b0, 1'b0);
        run(`OPC_SKIP_NONZERO, 1'b1, 1'b0, 8'hFF, 8'h00, 1'b0, 1'b1, 1'b1);
        run(`OPC_SKIP_NONZERO, 1'b0, 1'b1, 8'h05, 8'h05, 1'b1, 1'b0, 1'b1);
    endtask : t_nonzero
    task automatic t_indexed;
        run(`OPC_SKIP_ZERO, 1'b0, 1'b0, 8'h5F, 8'h03, 1'b1, 1'b0, 1'b0);
        run(`OPC_SKIP_ZERO, 1'b1, 1'b0, 8'h60, 8'h03, 1'b1, 1'b0, 1'b0);
        run(`OPC_SKIP_NONZERO, 1'b1, 1'b0, 8'h00, 8'h03, 1'b0, 1'b0, 1'b1);
    endtask : t_indexed
    // A neighbouring decrement opcode must not start this block.
    task automatic t_refused;
        while (!(cycle_end_o === 1'b1 && busy_o === 1'b0)) begin
            @(posedge clk_sys_i);
            #1;
        end
        instr_i = 16'h07A3;
        instr_valid_i = 1'b1;
        repeat (8) begin
            @(posedge clk_sys_i);
            #1;
            cmp_v({busy_o, wreg_we_o, file_we_o}, 12'h000);
        end
        instr_valid_i = 1'b0;
    endtask : t_refused
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1;
        resetn_i = 1'b1;
        t_zero();
        t_nonzero();
        t_indexed();
        t_refused();
        tally_and_finish();
    end
endmodule : tb_decrement_skip_instructions
